// *** include/slg_consts.svh ***
// register offsets, field positions, reset values and timing counts
// assumes byte addressing on a 32-bit apb bus
`ifndef SLG_CONSTS_SVH
`define SLG_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SLG_OFF_CTRL    8'h00
`define SLG_OFF_UPPER   8'h04
`define SLG_OFF_LOWER   8'h08
`define SLG_OFF_DELAY   8'h0c
`define SLG_OFF_DWELL   8'h10
`define SLG_OFF_RDELAY  8'h14
`define SLG_OFF_DECEL   8'h18
`define SLG_OFF_STATUS  8'h1c
`define SLG_OFF_SPEED   8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SLG_CTRL_ACT    0
`define SLG_CTRL_REACT  1
`define SLG_ST_ACTIVE   0
`define SLG_ST_ERR      1
`define SLG_ST_STATE    2
`define SLG_ST_RAMP     4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SLG_RST_LIMIT   16'h0000
`define SLG_RST_TIME    16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLG_MS_NS       1000000
`define SLG_CLK_NS      50

`endif

// *** include/slg_pkg.sv ***
// types shared by the speed limit guard files
// assumes slg_consts.svh is available on the include path
package slg_pkg;

  typedef enum logic [1:0] {
    SLG_TORQUE_OFF,
    SLG_STOP_A,
    SLG_STOP_B
  } slg_react_t;

  typedef enum logic [1:0] {
    SLG_IDLE,
    SLG_ARMED,
    SLG_ENFORCE
  } slg_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } slg_apb_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] speed;
  } slg_sample_t;

endpackage : slg_pkg

// *** hw/slg_ms_tick.sv ***
// millisecond tick for the speed limit guard
// assumes CLK at the rate given in slg_consts.svh
`timescale 1ns/1ps
`include "slg_consts.svh"
module slg_ms_tick #(
  parameter int unsigned MS_CYCLES = `SLG_MS_NS / `SLG_CLK_NS
) (
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic CE,
  input  wire logic RUN,
  output logic      TICK
);

  logic [15:0] cnt_reg;

  // phase restarts whenever the guard is not running
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= 16'h0000;
      TICK    <= 1'b0;
    end else if (CE) begin
      if (!RUN) begin
        cnt_reg <= 16'h0000;
        TICK    <= 1'b0;
      end else if (cnt_reg == 16'(MS_CYCLES - 1)) begin
        cnt_reg <= 16'h0000;
        TICK    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
        TICK    <= 1'b0;
      end
    end
  end

  tick_period_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && RUN && TICK |=> !TICK)
    else $error("tick lasted more than one cycle");

endmodule : slg_ms_tick

// *** hw/slg_guard.sv ***
// speed limit guard: delay, dwell and deceleration-ramp start paths
// assumes speed samples arrive on CLK, one strobe per control cycle
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "slg_consts.svh"

module slg_guard
  import slg_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SLG_MS_NS / `SLG_CLK_NS
) (
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  CE,
  input  wire slg_pkg::slg_apb_t     APB,
  output logic                       PREADY,
  output logic                       PSLVERR,
  output logic [31:0]                PRDATA,
  input  wire slg_pkg::slg_sample_t  SAMPLE,
  output logic                       STATUS_ACTIVE,
  output logic                       ERR_STROBE,
  output slg_pkg::slg_react_t        REACT
);

  import slg_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [17:0] wide(input logic [15:0] v);
    wide = 18'(signed'(v));
  endfunction : wide

  function automatic logic in_band(input logic [15:0] s,
                                   input logic [15:0] lo,
                                   input logic [15:0] up);
    in_band = (wide(s) >= wide(lo)) && (wide(s) <= wide(up));
  endfunction : in_band

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic               act_reg;
  slg_react_t         react_reg;
  logic [15:0]        up_reg;
  logic [15:0]        lo_reg;
  logic [15:0]        dly_reg;
  logic [15:0]        dwl_reg;
  logic [15:0]        rdl_reg;
  logic [15:0]        dec_reg;
  logic [15:0]        spd_reg;
  logic               err_reg;
  logic               in_rng_reg;
  slg_state_t         state_reg;
  slg_state_t         state_next;
  logic [15:0]        dly_cnt_reg;
  logic [15:0]        dwl_cnt_reg;
  logic [15:0]        rdl_cnt_reg;
  logic               ramp_on_reg;
  logic signed [17:0] rup_reg;
  logic signed [17:0] rlo_reg;
  logic signed [17:0] diff;
  logic               ms_tick;
  logic               wr;
  logic               rd_setup;
  logic               mapped;
  logic               cfg_wr_ok;
  logic               smp_in;
  logic               env_ok;
  logic               err_rng;
  logic               err_ramp;
  logic               err_now;
  logic               dly_done;
  logic               dwl_done;
  logic               ramp_done;
  logic               arming;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign mapped    = (APB.paddr <= `SLG_OFF_SPEED) && (APB.paddr[1:0] == 2'b00);
  assign wr        = APB.psel && APB.penable && APB.pwrite && mapped;
  assign rd_setup  = APB.psel && !APB.penable && !APB.pwrite;
  assign cfg_wr_ok = wr && !act_reg;
  assign PREADY    = 1'b1;
  assign PSLVERR   = APB.psel && APB.penable && !mapped;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_reg   <= 1'b0;
      react_reg <= SLG_TORQUE_OFF;
    end else if (CE && wr && APB.paddr == `SLG_OFF_CTRL) begin
      act_reg <= APB.pwdata[`SLG_CTRL_ACT];
      if (!act_reg) begin
        // code 3 is not a reaction; fall back to the safest one
        unique case (APB.pwdata[`SLG_CTRL_REACT +: 2])
          2'h1:    react_reg <= SLG_STOP_A;
          2'h2:    react_reg <= SLG_STOP_B;
          default: react_reg <= SLG_TORQUE_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      up_reg  <= `SLG_RST_LIMIT;
      lo_reg  <= `SLG_RST_LIMIT;
      dly_reg <= `SLG_RST_TIME;
      dwl_reg <= `SLG_RST_TIME;
      rdl_reg <= `SLG_RST_TIME;
      dec_reg <= `SLG_RST_LIMIT;
    end else if (CE && cfg_wr_ok) begin
      unique case (APB.paddr)
        `SLG_OFF_UPPER:  up_reg  <= APB.pwdata[15:0];
        `SLG_OFF_LOWER:  lo_reg  <= APB.pwdata[15:0];
        `SLG_OFF_DELAY:  dly_reg <= APB.pwdata[15:0];
        `SLG_OFF_DWELL:  dwl_reg <= APB.pwdata[15:0];
        `SLG_OFF_RDELAY: rdl_reg <= APB.pwdata[15:0];
        `SLG_OFF_DECEL:  dec_reg <= APB.pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (CE && rd_setup) begin
      unique case (APB.paddr)
        `SLG_OFF_CTRL:   PRDATA <= {29'h0, react_reg, act_reg};
        `SLG_OFF_UPPER:  PRDATA <= {16'h0, up_reg};
        `SLG_OFF_LOWER:  PRDATA <= {16'h0, lo_reg};
        `SLG_OFF_DELAY:  PRDATA <= {16'h0, dly_reg};
        `SLG_OFF_DWELL:  PRDATA <= {16'h0, dwl_reg};
        `SLG_OFF_RDELAY: PRDATA <= {16'h0, rdl_reg};
        `SLG_OFF_DECEL:  PRDATA <= {16'h0, dec_reg};
        `SLG_OFF_STATUS: PRDATA <= {27'h0, ramp_on_reg, state_reg, err_reg,
                                    STATUS_ACTIVE};
        `SLG_OFF_SPEED:  PRDATA <= {16'h0, spd_reg};
        default:         PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // sticky error, write one to clear; a new error wins over the clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      err_reg <= 1'b0;
    end else if (CE) begin
      if (err_now) begin
        err_reg <= 1'b1;
      end else if (wr && APB.paddr == `SLG_OFF_STATUS && APB.pwdata[`SLG_ST_ERR]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // speed samples and millisecond time base
  // ----------------------------------------------------------------
  assign smp_in = SAMPLE.valid;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spd_reg    <= 16'h0000;
      in_rng_reg <= 1'b0;
    end else if (CE && smp_in) begin
      spd_reg    <= SAMPLE.speed;
      in_rng_reg <= in_band(SAMPLE.speed, lo_reg, up_reg);
    end
  end

  slg_ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .CLK    (CLK),
    .ARST_N (ARST_N),
    .CE     (CE),
    .RUN    (act_reg),
    .TICK   (ms_tick)
  );

  // ----------------------------------------------------------------
  // checks and start conditions
  // ----------------------------------------------------------------
  always_comb begin
    diff = 18'sd0;
    if (wide(spd_reg) > wide(up_reg)) begin
      diff = wide(spd_reg) - wide(up_reg);
    end else if (wide(spd_reg) < wide(lo_reg)) begin
      diff = wide(lo_reg) - wide(spd_reg);
    end
  end

  assign env_ok    = (wide(SAMPLE.speed) <= rup_reg) && (wide(SAMPLE.speed) >= rlo_reg);
  assign err_rng   = smp_in && state_reg == SLG_ENFORCE && act_reg
                   && !in_band(SAMPLE.speed, lo_reg, up_reg);
  assign err_ramp  = smp_in && state_reg == SLG_ARMED && act_reg && ramp_on_reg
                   && !env_ok;
  assign err_now   = err_rng || err_ramp;
  assign dly_done  = dly_cnt_reg >= dly_reg;
  assign dwl_done  = (dwl_reg != 16'h0000) && (dwl_cnt_reg >= dwl_reg);
  assign ramp_done = ramp_on_reg && (rup_reg <= wide(up_reg));
  assign arming    = state_reg == SLG_IDLE && act_reg && dly_reg != 16'h0000;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SLG_IDLE: begin
        if (act_reg) begin
          state_next = (dly_reg == 16'h0000) ? SLG_ENFORCE : SLG_ARMED;
        end
      end
      SLG_ARMED: begin
        if (err_now || dly_done || dwl_done || ramp_done) begin
          state_next = SLG_ENFORCE;
        end
      end
      SLG_ENFORCE: state_next = SLG_ENFORCE;
    endcase
    if (!act_reg) begin
      state_next = SLG_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= SLG_IDLE;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dly_cnt_reg <= 16'h0000;
      rdl_cnt_reg <= 16'h0000;
    end else if (CE) begin
      if (state_reg != SLG_ARMED) begin
        dly_cnt_reg <= 16'h0000;
        rdl_cnt_reg <= 16'h0000;
      end else if (ms_tick) begin
        dly_cnt_reg <= dly_cnt_reg + 16'h0001;
        if (rdl_cnt_reg != 16'hffff) begin
          rdl_cnt_reg <= rdl_cnt_reg + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dwl_cnt_reg <= 16'h0000;
    end else if (CE) begin
      if (state_reg != SLG_ARMED || dwl_reg == 16'h0000) begin
        dwl_cnt_reg <= 16'h0000;
      end else if (smp_in && !in_band(SAMPLE.speed, lo_reg, up_reg)) begin
        dwl_cnt_reg <= 16'h0000;
      end else if (ms_tick && in_rng_reg && dwl_cnt_reg != 16'hffff) begin
        dwl_cnt_reg <= dwl_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // deceleration ramp
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ramp_on_reg <= 1'b0;
      rup_reg     <= 18'sd0;
      rlo_reg     <= 18'sd0;
    end else if (CE) begin
      if (arming) begin
        ramp_on_reg <= 1'b0;
        rup_reg     <= wide(up_reg) + diff;
        rlo_reg     <= wide(lo_reg) - diff;
      end else if (state_reg != SLG_ARMED) begin
        ramp_on_reg <= 1'b0;
      end else if (!ramp_on_reg) begin
        ramp_on_reg <= (dec_reg != 16'h0000) && (rdl_cnt_reg >= rdl_reg);
      end else if (ms_tick) begin
        rup_reg <= rup_reg - 18'(dec_reg);
        rlo_reg <= rlo_reg + 18'(dec_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign STATUS_ACTIVE = state_reg == SLG_ENFORCE;
  assign REACT         = react_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ERR_STROBE <= 1'b0;
    end else if (CE) begin
      ERR_STROBE <= err_now;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  drop_stops_a: assert property (CE && !act_reg |=> !STATUS_ACTIVE)
    else $error("enforcement survived a cleared activation bit");
  zero_delay_a: assert property (CE && state_reg == SLG_IDLE && act_reg
    && dly_reg == 16'h0000 |=> STATUS_ACTIVE)
    else $error("zero delay did not enforce at once");
  range_err_a: assert property (CE && err_rng |=> ERR_STROBE && STATUS_ACTIVE)
    else $error("range violation not reported");
  quiet_wait_a: assert property (state_reg == SLG_ARMED && !ramp_on_reg
    |-> !err_now && !STATUS_ACTIVE)
    else $error("error flagged during plain delay wait");
  delay_bound_a: assert property (CE && act_reg && state_reg == SLG_ARMED
    && dly_cnt_reg >= dly_reg |=> STATUS_ACTIVE)
    else $error("delay expiry did not start enforcement");
  dwell_start_a: assert property (CE && act_reg && state_reg == SLG_ARMED
    && dwl_reg != 16'h0000 && dwl_cnt_reg >= dwl_reg |=> STATUS_ACTIVE)
    else $error("dwell expiry did not start enforcement");
  dwell_off_a: assert property (dwl_reg == 16'h0000 && act_reg
    |=> dwl_cnt_reg == 16'h0000)
    else $error("dwell counted while disabled");
  ramp_err_a: assert property (CE && err_ramp |=> ERR_STROBE && STATUS_ACTIVE)
    else $error("ramp violation not reported");
  ramp_step_a: assert property (CE && ms_tick && ramp_on_reg && !arming
    && state_reg == SLG_ARMED |=> rup_reg == $past(rup_reg) - 18'(dec_reg))
    else $error("ramp did not step by the deceleration value");
  ramp_load_a: assert property (CE && arming
    |=> rup_reg - wide(up_reg) == wide(lo_reg) - rlo_reg)
    else $error("ramps not loaded symmetrically");
  hold_enf_a: assert property (CE && STATUS_ACTIVE && act_reg
    ##1 CE && act_reg |-> STATUS_ACTIVE)
    else $error("enforcement ended while still activated");

endmodule : slg_guard

// *** testbench/slg_ctl_model.sv ***
// safety controller model: apb master plus a speed sample source
// assumes zero or more wait states from the guard, one clock
`timescale 1ns/1ps
module slg_ctl_model
  import slg_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  PREADY,
  input  wire logic                  PSLVERR,
  input  wire logic [31:0]           PRDATA,
  input  wire logic [15:0]           SPEED,
  output slg_pkg::slg_apb_t          APB,
  output slg_pkg::slg_sample_t       SAMPLE
);
  logic [1:0] phase;

  initial APB = '0;

  // one transfer; request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge CLK);
    APB <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge CLK);
    APB.penable <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    // released lines show no stale value
    APB <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask : xfer

  // one sample strobe every four cycles
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase  <= 2'h0;
      SAMPLE <= '0;
    end else begin
      phase  <= phase + 2'h1;
      SAMPLE <= '{valid: phase == 2'h3, speed: (phase == 2'h3) ? SPEED : ~SPEED};
    end
  end
endmodule : slg_ctl_model

// *** testbench/test_speed_limit_monitor.sv ***
// self-checking bench for the speed limit guard
// assumes MS_CYCLES of 10, so one millisecond is ten clocks
`timescale 1ns/1ps
`include "slg_consts.svh"
module test_speed_limit_monitor;
  import slg_pkg::*;
  logic              clk;
  logic              arst_n;
  logic              ce;
  slg_apb_t          apb;
  slg_sample_t       sample;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic              status_active;
  logic              err_strobe;
  slg_react_t        react;
  logic [15:0]       spd;
  int                fails;
  int                check_count;

  slg_guard #(.MS_CYCLES(10)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .CE(ce), .APB(apb), .PREADY(pready),
    .PSLVERR(pslverr), .PRDATA(prdata), .SAMPLE(sample),
    .STATUS_ACTIVE(status_active), .ERR_STROBE(err_strobe), .REACT(react));

  slg_ctl_model i_ctl (
    .CLK(clk), .ARST_N(arst_n), .PREADY(pready), .PSLVERR(pslverr),
    .PRDATA(prdata), .SPEED(spd), .APB(apb), .SAMPLE(sample));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] rd;
    logic        err;
    i_ctl.xfer(1'b1, a, 32'(d), rd, err);
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic eerr);
    logic [31:0] rd;
    logic        err;
    i_ctl.xfer(1'b0, a, 32'h0, rd, err);
    #1;
    cmp_word(rd, e);
    cmp_bit(err, eerr);
  endtask : rd_chk

  task automatic cfg(input int up, input int lo, input int dly, input int dw,
                     input int rdly, input int dec);
    wr(`SLG_OFF_UPPER, up);
    wr(`SLG_OFF_LOWER, lo);
    wr(`SLG_OFF_DELAY, dly);
    wr(`SLG_OFF_DWELL, dw);
    wr(`SLG_OFF_RDELAY, rdly);
    wr(`SLG_OFF_DECEL, dec);
  endtask : cfg

  // wait a bounded time for status or error strobe to reach a level
  task automatic wait_sig(input bit use_err, input logic e, input int n);
    int k;
    k = 0;
    while ((use_err ? err_strobe : status_active) !== e && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp_bit(use_err ? err_strobe : status_active, e);
  endtask : wait_sig

  // neither status nor error may show for n cycles
  task automatic hold_low(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      bad = bad | status_active | err_strobe;
    end
    cmp_bit(bad, 1'b0);
  endtask : hold_low

  task automatic set_spd(input int v);
    @(posedge clk);
    spd <= 16'(v);
    repeat (8) @(posedge clk);
    #1;
  endtask : set_spd

  task automatic stop_act();
    wr(`SLG_OFF_CTRL, 0);
    wait_sig(1'b0, 1'b0, 3);
  endtask : stop_act

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(`SLG_OFF_UPPER, 32'h0, 1'b0);
    rd_chk(`SLG_OFF_STATUS, 32'h0, 1'b0);
    rd_chk(8'h24, 32'h0, 1'b1);
    wr(`SLG_OFF_UPPER, 100);
    rd_chk(`SLG_OFF_UPPER, 32'h64, 1'b0);
    wr(`SLG_OFF_CTRL, 2);
    rd_chk(`SLG_OFF_CTRL, 32'h2, 1'b0);
    cmp_word({30'h0, react}, 32'h1);
    wr(`SLG_OFF_CTRL, 6);
    rd_chk(`SLG_OFF_CTRL, 32'h0, 1'b0);
  endtask : t_regs

  task automatic t_zero();
    cfg(100, -100, 0, 0, 0, 0);
    for (int r = 0; r < 3; r++) begin
      set_spd(0);
      wr(`SLG_OFF_CTRL, (r << 1) | 1);
      wait_sig(1'b0, 1'b1, 4);
      set_spd(200);
      wait_sig(1'b1, 1'b1, 12);
      cmp_word({30'h0, react}, 32'(r));
      repeat (10) @(posedge clk);
      #1;
      cmp_bit(status_active, 1'b1);
      stop_act();
    end
  endtask : t_zero

  task automatic t_delay();
    cfg(100, -100, 3, 0, 0, 0);
    set_spd(200);
    wr(`SLG_OFF_CTRL, 1);
    hold_low(25);
    // clock enable low must freeze the delay timer
    @(posedge clk) ce <= 1'b0;
    hold_low(30);
    @(posedge clk) ce <= 1'b1;
    wait_sig(1'b0, 1'b1, 40);
    wait_sig(1'b1, 1'b1, 8);
    stop_act();
  endtask : t_delay

  task automatic t_abort();
    cfg(100, -100, 5, 0, 0, 0);
    wr(`SLG_OFF_CTRL, 1);
    hold_low(20);
    wr(`SLG_OFF_CTRL, 0);
    hold_low(80);
  endtask : t_abort

  task automatic t_dwell();
    cfg(100, -100, 20, 2, 0, 0);
    set_spd(0);
    wr(`SLG_OFF_CTRL, 1);
    hold_low(8);
    wait_sig(1'b0, 1'b1, 60);
    stop_act();
  endtask : t_dwell

  task automatic t_ramp_ok();
    cfg(100, -100, 20, 0, 1, 10);
    set_spd(130);
    wr(`SLG_OFF_CTRL, 1);
    @(posedge clk) spd <= 16'(95);
    hold_low(20);
    wait_sig(1'b0, 1'b1, 40);
    stop_act();
  endtask : t_ramp_ok

  task automatic t_ramp_err();
    set_spd(130);
    wr(`SLG_OFF_CTRL, 1);
    hold_low(15);
    wait_sig(1'b1, 1'b1, 30);
    cmp_bit(status_active, 1'b1);
    wr(`SLG_OFF_UPPER, 55);
    rd_chk(`SLG_OFF_STATUS, 32'hb, 1'b0);
    stop_act();
    rd_chk(`SLG_OFF_UPPER, 32'h64, 1'b0);
    rd_chk(`SLG_OFF_SPEED, 32'h82, 1'b0);
    wr(`SLG_OFF_STATUS, 2);
    rd_chk(`SLG_OFF_STATUS, 32'h0, 1'b0);
  endtask : t_ramp_err

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    fails = 0;
    check_count = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    spd = 16'h0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_zero();
    t_delay();
    t_abort();
    t_dwell();
    t_ramp_ok();
    t_ramp_err();
    print_verdict();
  end
endmodule : test_speed_limit_monitor
